// file: common/cfcp_map.vh
`ifndef CFCP_MAP_VH
`define CFCP_MAP_VH

// load scheme codes, strap input
`define CFCP_SCHEME_W       2
`define CFCP_HOST_SERIAL    2'h0
`define CFCP_HOST_BYTEWIDE  2'h1
`define CFCP_SELF_SERIAL    2'h2
`define CFCP_SELF_FLASH     2'h3

// pin controller states
`define CFCP_ST_IDLE        2'h0
`define CFCP_ST_LOAD        2'h1
`define CFCP_ST_USER        2'h2

// data lines
`define CFCP_DATA_W         16
`define CFCP_BYTE_W         8
`define CFCP_BIT_CNT_W      3

// stream buffer
`define CFCP_FIFO_DEPTH     8
`define CFCP_FIFO_AW        3

// self-clocked link timing
`define CFCP_CLK_HZ         100000000
`define CFCP_LINK_HZ        12500000
`define CFCP_HALF_CYC       ((`CFCP_CLK_HZ / `CFCP_LINK_HZ) / 2)
`define CFCP_DIV_W          4

// serial flash read request, shifted out on the command line
`define CFCP_CMD_W          32
`define CFCP_CMD_CNT_W      6
`define CFCP_CMD_CNT_INIT   6'h20
`define CFCP_CMD_WORD       32'h03000000
`endif

// file: core/cfcp_pins.v
`timescale 1ns/1ns
// Overview of operation
// - host-clocked schemes: configuration clock pin is an input from outside
// - host-clocked schemes: data captured on every rising configuration clock edge
// - serial flash scheme: device drives configuration clock as output
// - parallel flash scheme: device drives configuration clock as output
// - self-clocked schemes: clock driven inactive after configuration completes
// - self-clocked schemes: clock pin optionally handed to user logic afterwards
// - host-clocked schemes: clock pin never offered as user input/output
// - clock toggling after configuration is ignored
// - serial schemes: one data bit per clock on data line zero
// - after serial flash load, line zero stays input, user may read it
// - after host-clocked load, line zero is user I/O per dual-purpose setting
// - after parallel flash load, line zero is bidirectional under user control
// - serial flash scheme: line one drives read command toward flash
// - host bytewide and parallel flash schemes: line one is a configuration data input
// - after serial flash load, line one stays output, user may drive it
// - host-clocked serial scheme: line one tri-stated during configuration
// - after host-clocked bytewide load, line one is user I/O per setting
// - parallel flash scheme: data byte-wide on low eight or word-wide on sixteen
// - after parallel flash load, line one is bidirectional under user control
// - serial flash scheme: active-low select enables flash during configuration
// - after parallel flash load, upper eight lines are user bidirectional
`include "cfcp_map.vh"

////////////////////////////////////////////////////////////////////////////////

module cfcp_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // clock and reset
   input  wire             i_clk,
   input  wire             i_sys_rst,
   // fill side
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   // drain side
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_reg;
   reg [AW-1:0]    rd_ptr_reg;
   reg [AW:0]      count_reg;
   reg [AW:0]      count_next;
   wire            push;
   wire            pop;

   assign o_in_ready  = (count_reg != DEPTH[AW:0]);
   assign o_out_valid = (count_reg != {(AW+1){1'b0}});
   assign o_out_data  = mem_reg[rd_ptr_reg];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always @* begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
         count_next = count_reg - {{AW{1'b0}}, 1'b1};
      end
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end else begin
         count_reg <= count_next;
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ?
                          {AW{1'b0}} : wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ?
                          {AW{1'b0}} : rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
      end
   end

   // storage has no reset; only occupied words are ever read
   always @(posedge i_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= i_in_data;
      end
   end

endmodule

////////////////////////////////////////////////////////////////////////////////

module cfcp_pins (
   // clock and reset
   input  wire                      i_clk,
   input  wire                      i_sys_rst,
   // control
   input  wire [`CFCP_SCHEME_W-1:0] i_scheme,
   input  wire                      i_flash_word_mode,
   input  wire                      i_start,
   input  wire                      i_load_done,
   output wire                      o_loading,
   output wire                      o_user_mode,
   output wire                      o_overrun,
   // configuration clock pin
   input  wire                      i_config_clock,
   output wire                      o_config_clock,
   output wire                      o_config_clock_oe,
   // data pins, line one doubles as flash_cmd_out
   input  wire [`CFCP_DATA_W-1:0]   i_data,
   output wire [`CFCP_DATA_W-1:0]   o_data,
   output wire [`CFCP_DATA_W-1:0]   o_data_oe,
   // flash select
   output wire                      o_flash_select_n,
   // user-mode pin control
   input  wire                      i_user_clk_io_en,
   input  wire                      i_user_clk_out,
   input  wire                      i_user_clk_oe,
   input  wire [`CFCP_DATA_W-1:0]   i_user_out,
   input  wire [`CFCP_DATA_W-1:0]   i_user_oe,
   output wire [`CFCP_DATA_W-1:0]   o_user_in,
   output wire                      o_user_clk_in,
   // configuration stream
   output wire                      o_cfg_valid,
   input  wire                      i_cfg_ready,
   output wire [`CFCP_DATA_W-1:0]   o_cfg_data
);

   // line zero direction in user mode, one bit per scheme
   function user_d0_can_drive;
      input [`CFCP_SCHEME_W-1:0] sch;
      begin
         user_d0_can_drive = (sch != `CFCP_SELF_SERIAL);
      end
   endfunction

   function is_self_clocked;
      input [`CFCP_SCHEME_W-1:0] sch;
      begin
         is_self_clocked = (sch == `CFCP_SELF_SERIAL) || (sch == `CFCP_SELF_FLASH);
      end
   endfunction

   reg  [1:0]                state_reg;
   reg  [`CFCP_SCHEME_W-1:0] scheme_reg;
   reg                       word_mode_reg;
   reg                       overrun_reg;
   reg                       cclk_s1_reg;
   reg                       cclk_s2_reg;
   reg                       cclk_s3_reg;
   reg  [`CFCP_DATA_W-1:0]   data_s1_reg;
   reg  [`CFCP_DATA_W-1:0]   data_s2_reg;
   reg                       gen_clk_reg;
   reg  [`CFCP_DIV_W-1:0]    div_reg;
   reg  [`CFCP_CMD_W-1:0]    cmd_reg;
   reg  [`CFCP_CMD_CNT_W-1:0] cmd_cnt_reg;
   reg  [`CFCP_BYTE_W-1:0]   shift_reg;
   reg  [`CFCP_BIT_CNT_W-1:0] bit_cnt_reg;
   reg                       push_reg;
   reg  [`CFCP_DATA_W-1:0]   push_data_reg;
   reg                       cclk_out_reg;
   reg                       cclk_oe_reg;
   reg  [`CFCP_DATA_W-1:0]   dout_reg;
   reg  [`CFCP_DATA_W-1:0]   doe_reg;
   reg                       sel_n_reg;
   wire                      loading;
   wire                      self_clk;
   wire                      host_rise;
   wire                      gen_rise;
   wire                      gen_fall;
   wire                      sample;
   wire                      cmd_busy;
   wire                      fifo_ready;

   assign loading  = (state_reg == `CFCP_ST_LOAD);
   assign self_clk = is_self_clocked(scheme_reg);
   assign cmd_busy = (scheme_reg == `CFCP_SELF_SERIAL) &&
                     (cmd_cnt_reg != {`CFCP_CMD_CNT_W{1'b0}});

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         cclk_s1_reg <= 1'b0;
         cclk_s2_reg <= 1'b0;
         cclk_s3_reg <= 1'b0;
         data_s1_reg <= {`CFCP_DATA_W{1'b0}};
         data_s2_reg <= {`CFCP_DATA_W{1'b0}};
      end else begin
         cclk_s1_reg <= i_config_clock;
         cclk_s2_reg <= cclk_s1_reg;
         cclk_s3_reg <= cclk_s2_reg;
         data_s1_reg <= i_data;
         data_s2_reg <= data_s1_reg;
      end
   end

   // host edges only count while loading, so user-mode toggling does nothing
   assign host_rise = loading && !self_clk && cclk_s2_reg && !cclk_s3_reg;

////////////////////////////////////////////////////////////////////////////////
// sequencing, scheme capture

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_reg     <= `CFCP_ST_IDLE;
         scheme_reg    <= `CFCP_HOST_SERIAL;
         word_mode_reg <= 1'b0;
      end else begin
         case (state_reg)
            `CFCP_ST_IDLE: begin
               if (i_start) begin
                  scheme_reg    <= i_scheme;
                  word_mode_reg <= i_flash_word_mode;
                  state_reg     <= `CFCP_ST_LOAD;
               end
            end
            `CFCP_ST_LOAD: begin
               if (i_load_done) begin
                  state_reg <= `CFCP_ST_USER;
               end
            end
            `CFCP_ST_USER: begin
               state_reg <= `CFCP_ST_USER;
            end
            default: begin
               state_reg <= `CFCP_ST_IDLE;
            end
         endcase
      end
   end

////////////////////////////////////////////////////////////////////////////////
// self-clocked link clock; stalls while the buffer is full

   assign gen_rise = loading && self_clk && fifo_ready && !gen_clk_reg &&
                     (div_reg == `CFCP_HALF_CYC - 1);
   assign gen_fall = loading && self_clk && fifo_ready && gen_clk_reg &&
                     (div_reg == `CFCP_HALF_CYC - 1);

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         gen_clk_reg <= 1'b0;
         div_reg     <= {`CFCP_DIV_W{1'b0}};
      end else if (loading && self_clk && fifo_ready) begin
         if (div_reg == `CFCP_HALF_CYC - 1) begin
            div_reg     <= {`CFCP_DIV_W{1'b0}};
            gen_clk_reg <= !gen_clk_reg;
         end else begin
            div_reg <= div_reg + {{(`CFCP_DIV_W-1){1'b0}}, 1'b1};
         end
      end else if (!loading) begin
         gen_clk_reg <= 1'b0;
         div_reg     <= {`CFCP_DIV_W{1'b0}};
      end
   end

////////////////////////////////////////////////////////////////////////////////
// read command toward the serial flash, changed on falling edges

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         cmd_reg     <= {`CFCP_CMD_W{1'b0}};
         cmd_cnt_reg <= {`CFCP_CMD_CNT_W{1'b0}};
      end else if (state_reg == `CFCP_ST_IDLE && i_start &&
                   i_scheme == `CFCP_SELF_SERIAL) begin
         cmd_reg     <= `CFCP_CMD_WORD;
         cmd_cnt_reg <= `CFCP_CMD_CNT_INIT;
      end else if (gen_rise && cmd_busy) begin
         cmd_cnt_reg <= cmd_cnt_reg - {{(`CFCP_CMD_CNT_W-1){1'b0}}, 1'b1};
      end else if (gen_fall) begin
         cmd_reg <= {cmd_reg[`CFCP_CMD_W-2:0], 1'b0};
      end
   end

////////////////////////////////////////////////////////////////////////////////
// capture; synced data is settled since the half period spans the sync delay

   assign sample = host_rise || (gen_rise && !cmd_busy);

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         shift_reg     <= {`CFCP_BYTE_W{1'b0}};
         bit_cnt_reg   <= {`CFCP_BIT_CNT_W{1'b0}};
         push_reg      <= 1'b0;
         push_data_reg <= {`CFCP_DATA_W{1'b0}};
         overrun_reg   <= 1'b0;
      end else begin
         push_reg <= 1'b0;
         if (state_reg == `CFCP_ST_IDLE) begin
            bit_cnt_reg <= {`CFCP_BIT_CNT_W{1'b0}};
         end
         // host cannot be stalled, so a full buffer loses the word
         if (push_reg && !fifo_ready) begin
            overrun_reg <= 1'b1;
         end
         if (sample) begin
            case (scheme_reg)
               `CFCP_HOST_SERIAL, `CFCP_SELF_SERIAL: begin
                  shift_reg   <= {data_s2_reg[0], shift_reg[`CFCP_BYTE_W-1:1]};
                  bit_cnt_reg <= bit_cnt_reg + {{(`CFCP_BIT_CNT_W-1){1'b0}}, 1'b1};
                  if (bit_cnt_reg == {`CFCP_BIT_CNT_W{1'b1}}) begin
                     push_reg      <= 1'b1;
                     push_data_reg <= {{(`CFCP_DATA_W-`CFCP_BYTE_W){1'b0}},
                                       data_s2_reg[0], shift_reg[`CFCP_BYTE_W-1:1]};
                  end
               end
               `CFCP_HOST_BYTEWIDE: begin
                  push_reg      <= 1'b1;
                  push_data_reg <= {{(`CFCP_DATA_W-`CFCP_BYTE_W){1'b0}},
                                    data_s2_reg[`CFCP_BYTE_W-1:0]};
               end
               `CFCP_SELF_FLASH: begin
                  push_reg      <= 1'b1;
                  push_data_reg <= word_mode_reg ? data_s2_reg :
                                   {{(`CFCP_DATA_W-`CFCP_BYTE_W){1'b0}},
                                    data_s2_reg[`CFCP_BYTE_W-1:0]};
               end
               default: begin
                  push_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   cfcp_fifo #(
      .WIDTH (`CFCP_DATA_W),
      .DEPTH (`CFCP_FIFO_DEPTH),
      .AW    (`CFCP_FIFO_AW)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_in_valid  (push_reg),
      .o_in_ready  (fifo_ready),
      .i_in_data   (push_data_reg),
      .o_out_valid (o_cfg_valid),
      .i_out_ready (i_cfg_ready),
      .o_out_data  (o_cfg_data)
   );

////////////////////////////////////////////////////////////////////////////////
// pin roles per scheme and phase

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         cclk_out_reg <= 1'b0;
         cclk_oe_reg  <= 1'b0;
         dout_reg     <= {`CFCP_DATA_W{1'b0}};
         doe_reg      <= {`CFCP_DATA_W{1'b0}};
         sel_n_reg    <= 1'b1;
      end else if (loading) begin
         cclk_out_reg <= gen_clk_reg;
         cclk_oe_reg  <= self_clk;
         dout_reg     <= {`CFCP_DATA_W{1'b0}};
         doe_reg      <= {`CFCP_DATA_W{1'b0}};
         sel_n_reg    <= !self_clk;
         if (scheme_reg == `CFCP_SELF_SERIAL) begin
            dout_reg[1] <= cmd_reg[`CFCP_CMD_W-1];
            doe_reg[1]  <= 1'b1;
         end
      end else if (state_reg == `CFCP_ST_USER) begin
         sel_n_reg <= 1'b1;
         if (self_clk && i_user_clk_io_en) begin
            cclk_out_reg <= i_user_clk_out;
            cclk_oe_reg  <= i_user_clk_oe;
         end else begin
            cclk_out_reg <= 1'b0;
            cclk_oe_reg  <= self_clk;
         end
         dout_reg    <= i_user_out;
         doe_reg     <= i_user_oe;
         doe_reg[0]  <= user_d0_can_drive(scheme_reg) && i_user_oe[0];
         if (scheme_reg == `CFCP_SELF_SERIAL) begin
            doe_reg[1] <= 1'b1;
         end
      end else begin
         cclk_out_reg <= 1'b0;
         cclk_oe_reg  <= 1'b0;
         dout_reg     <= {`CFCP_DATA_W{1'b0}};
         doe_reg      <= {`CFCP_DATA_W{1'b0}};
         sel_n_reg    <= 1'b1;
      end
   end

   assign o_config_clock    = cclk_out_reg;
   assign o_config_clock_oe = cclk_oe_reg;
   assign o_data            = dout_reg;
   assign o_data_oe         = doe_reg;
   assign o_flash_select_n  = sel_n_reg;
   assign o_loading         = loading;
   assign o_user_mode       = (state_reg == `CFCP_ST_USER);
   assign o_overrun         = overrun_reg;
   assign o_user_in         = data_s2_reg;
   // host-clocked pin stays private to the loader
   assign o_user_clk_in     = (o_user_mode && self_clk) ? cclk_s2_reg : 1'b0;

endmodule

// file: verif/cfcp_far.sv
`timescale 1ns/1ns
module cfcp_far (
   // device pin drives
   input  wire logic        i_dev_clk,
   input  wire logic        i_dev_clk_oe,
   input  wire logic [15:0] i_dev_data,
   input  wire logic [15:0] i_dev_data_oe,
   input  wire logic        i_sel_n,
   input  wire logic        i_serial,
   // resolved pin levels
   output wire logic        o_clk_pin,
   output wire logic [15:0] o_data_pin
);
   logic        host_clk;
   logic [15:0] far_data;
   logic [15:0] w;
   logic [31:0] cmd;
   int          rises;
   initial begin
      host_clk = 1'b0;
      far_data = 16'h0000;
      cmd = 32'h0;
      rises = 0;
   end
   assign o_clk_pin  = i_dev_clk_oe ? i_dev_clk : host_clk;
   assign o_data_pin = (i_dev_data & i_dev_data_oe) | (far_data & ~i_dev_data_oe);
   function automatic logic [15:0] word_at(input int n);
      return {8'ha5 ^ n[7:0], 8'h5a ^ n[7:0]};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   // host: data set while low, rise 40 ns later; clock rests low between frames
   task automatic send(input int n, input int extra, input bit serial);
      logic [15:0] v;
      for (int k = 0; k < n * (serial ? 8 : 1) + extra; k++) begin
         v = word_at(serial ? k / 8 : k);
         far_data = serial ? {15'h0, v[k % 8]} : v;
         #40 host_clk = 1'b1;
         #40 host_clk = 1'b0;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // flash: next data after each falling edge of the device clock
   always @(negedge i_sel_n) begin
      rises = 0;
      far_data = i_serial ? 16'h0000 : word_at(0);
   end
   // released flash lines must not keep a stale level
   always @(posedge i_sel_n) far_data = ~far_data;
   always @(posedge o_clk_pin) begin
      if (!i_sel_n) begin
         if (rises < 32) cmd = {cmd[30:0], o_data_pin[1]};
         rises = rises + 1;
      end
   end
   always @(negedge o_clk_pin) begin
      if (!i_sel_n) begin
         w = word_at(i_serial ? (rises - 32) / 8 : rises);
         far_data = i_serial ? {15'h0, (rises >= 32) ? w[(rises - 32) % 8] : 1'b1} : w;
      end
   end
endmodule

// file: verif/cfcp_pins_props.sv
`timescale 1ns/1ns
`include "cfcp_map.vh"
module cfcp_pins_props (
   // clock and reset
   input wire logic                      i_clk,
   input wire logic                      i_sys_rst,
   // control
   input wire logic [`CFCP_SCHEME_W-1:0] i_scheme,
   input wire logic                      i_start,
   input wire logic                      i_load_done,
   input wire logic                      o_loading,
   input wire logic                      o_user_mode,
   // pins
   input wire logic                      o_config_clock,
   input wire logic                      o_config_clock_oe,
   input wire logic [`CFCP_DATA_W-1:0]   o_data_oe,
   input wire logic                      o_flash_select_n,
   input wire logic                      i_user_clk_io_en,
   input wire logic                      i_user_clk_oe,
   input wire logic [`CFCP_DATA_W-1:0]   i_user_oe,
   input wire logic                      o_cfg_valid
);
   logic [`CFCP_SCHEME_W-1:0] sch_reg;
   logic                      self_clk;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // scheme as taken at start, later strap changes must not count
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sch_reg <= `CFCP_HOST_SERIAL;
      end else if (i_start && !o_loading && !o_user_mode) begin
         sch_reg <= i_scheme;
      end
   end
   assign self_clk = sch_reg[1];
   sequence s_idle_start;
      i_start && !o_loading && !o_user_mode;
   endsequence
   // pin registers lag the state by a cycle
   sequence s_load;
      o_loading && $past(o_loading);
   endsequence
   sequence s_user;
      o_user_mode && $past(o_user_mode);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   chk_start_load: assert property (s_idle_start |=> o_loading)
      else $error("load did not begin after start");
   chk_load_hold: assert property (o_loading && !i_load_done |=> o_loading)
      else $error("load ended without done");
   chk_host_clk_in: assert property (s_load ##0 !self_clk |-> !o_config_clock_oe)
      else $error("clock pin driven in host scheme");
   chk_self_clk_out: assert property (s_load ##0 self_clk |-> o_config_clock_oe && !o_flash_select_n)
      else $error("clock or select not driven in self scheme");
   chk_load_data_oe: assert property (s_load |-> o_data_oe == ((sch_reg == `CFCP_SELF_SERIAL) ? 16'h0002 : 16'h0000))
      else $error("data enables wrong during load");
   chk_host_no_user: assert property (o_user_mode && !self_clk |-> !o_config_clock_oe)
      else $error("clock pin driven after host load");
   chk_self_clk_idle: assert property (s_user ##0 (self_clk && !$past(i_user_clk_io_en)) |-> o_config_clock_oe && !o_config_clock)
      else $error("clock pin not parked after self load");
   chk_user_clk_pin: assert property (s_user ##0 (self_clk && $past(i_user_clk_io_en)) |-> o_config_clock_oe == $past(i_user_clk_oe))
      else $error("clock pin not under user control");
   chk_serial_user: assert property (s_user ##0 (sch_reg == `CFCP_SELF_SERIAL) |-> o_data_oe[1:0] == 2'b10)
      else $error("serial flash lines wrong in user mode");
   chk_user_data_oe: assert property (s_user ##0 (sch_reg != `CFCP_SELF_SERIAL) |-> o_data_oe == $past(i_user_oe))
      else $error("data enables not from user");
   chk_user_no_push: assert property (o_user_mode && $past(o_user_mode, 4) |-> !$rose(o_cfg_valid))
      else $error("word pushed in user mode");
endmodule
bind cfcp_pins cfcp_pins_props cfcp_pins_props_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_scheme(i_scheme), .i_start(i_start), .i_load_done(i_load_done), .o_loading(o_loading),
   .o_user_mode(o_user_mode), .o_config_clock(o_config_clock),
   .o_config_clock_oe(o_config_clock_oe), .o_data_oe(o_data_oe),
   .o_flash_select_n(o_flash_select_n), .i_user_clk_io_en(i_user_clk_io_en),
   .i_user_clk_oe(i_user_clk_oe), .i_user_oe(i_user_oe), .o_cfg_valid(o_cfg_valid));

// file: verif/testbench.sv
`timescale 1ns/1ns
`include "cfcp_map.vh"
module testbench;
   logic        i_clk, i_sys_rst, i_start, i_load_done, i_flash_word_mode, i_cfg_ready;
   logic [1:0]  i_scheme;
   logic        i_user_clk_io_en, i_user_clk_out, i_user_clk_oe, far_serial;
   logic [15:0] i_user_out, i_user_oe, o_data, o_data_oe, o_user_in, o_cfg_data, pin_data;
   logic        o_loading, o_user_mode, o_overrun, o_config_clock, o_config_clock_oe;
   logic        o_flash_select_n, o_user_clk_in, o_cfg_valid, pin_clk;
   int          error_cnt, check_count, cycles;
   cfcp_pins cfcp_pins_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scheme(i_scheme),
      .i_flash_word_mode(i_flash_word_mode), .i_start(i_start), .i_load_done(i_load_done),
      .o_loading(o_loading), .o_user_mode(o_user_mode), .o_overrun(o_overrun),
      .i_config_clock(pin_clk), .o_config_clock(o_config_clock),
      .o_config_clock_oe(o_config_clock_oe), .i_data(pin_data), .o_data(o_data),
      .o_data_oe(o_data_oe), .o_flash_select_n(o_flash_select_n),
      .i_user_clk_io_en(i_user_clk_io_en), .i_user_clk_out(i_user_clk_out),
      .i_user_clk_oe(i_user_clk_oe), .i_user_out(i_user_out), .i_user_oe(i_user_oe),
      .o_user_in(o_user_in), .o_user_clk_in(o_user_clk_in), .o_cfg_valid(o_cfg_valid),
      .i_cfg_ready(i_cfg_ready), .o_cfg_data(o_cfg_data));
   cfcp_far cfcp_far_i (.i_dev_clk(o_config_clock), .i_dev_clk_oe(o_config_clock_oe),
      .i_dev_data(o_data), .i_dev_data_oe(o_data_oe), .i_sel_n(o_flash_select_n),
      .i_serial(far_serial), .o_clk_pin(pin_clk), .o_data_pin(pin_data));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         error_cnt = error_cnt + 1;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic restart(input logic [1:0] sch, input logic wm, input logic ser);
      i_sys_rst = 1'b1;
      i_user_clk_io_en = 1'b0;
      i_user_clk_oe = 1'b0;
      tick(2);
      i_sys_rst = 1'b0;
      i_scheme = sch;
      i_flash_word_mode = wm;
      far_serial = ser;
      i_start = 1'b1;
      tick(1);
      i_start = 1'b0;
      tick(1);
      check("loading", o_loading, 1'b1);
   endtask
   task automatic pop(input logic [15:0] exp, input logic [15:0] mask);
      int t;
      t = 0;
      while (o_cfg_valid !== 1'b1 && t < 3000) begin
         tick(1);
         t++;
      end
      check("cfg_data", o_cfg_data & mask, exp & mask);
      i_cfg_ready = 1'b1;
      tick(1);
      i_cfg_ready = 1'b0;
      tick(1);
   endtask
   task automatic end_load();
      i_load_done = 1'b1;
      tick(1);
      i_load_done = 1'b0;
      tick(3);
      check("user_mode", o_user_mode, 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_host_bytewide();
      restart(`CFCP_HOST_BYTEWIDE, 1'b0, 1'b0);
      cfcp_far_i.send(10, 0, 1'b0);
      tick(10);
      check("clk_oe", o_config_clock_oe, 1'b0);
      check("data_oe", o_data_oe, 16'h0000);
      check("overrun", o_overrun, 1'b1);
      for (int k = 0; k < 8; k++) pop({8'h00, 8'h5a ^ k[7:0]}, 16'hffff);
      check("drained", o_cfg_valid, 1'b0);
      end_load();
      i_user_clk_io_en = 1'b1;
      i_user_clk_oe = 1'b1;
      cfcp_far_i.send(3, 0, 1'b0);
      tick(10);
      check("user_push", o_cfg_valid, 1'b0);
      check("clk_user", o_config_clock_oe, 1'b0);
      check("user_oe", o_data_oe, 16'h5a3c);
      check("user_out", o_data, 16'h0ff0);
      check("user_in", o_user_in, 16'haf70);
   endtask
   task automatic t_host_serial();
      restart(`CFCP_HOST_SERIAL, 1'b0, 1'b0);
      cfcp_far_i.send(2, 5, 1'b1);
      tick(10);
      check("line1_oe", o_data_oe[1], 1'b0);
      for (int k = 0; k < 2; k++) pop({8'h00, 8'h5a ^ k[7:0]}, 16'hffff);
      end_load();
      check("partial", o_cfg_valid, 1'b0);
   endtask
   task automatic t_self_serial();
      restart(`CFCP_SELF_SERIAL, 1'b0, 1'b1);
      tick(4);
      check("clk_oe", o_config_clock_oe, 1'b1);
      check("select", o_flash_select_n, 1'b0);
      check("cmd_oe", o_data_oe, 16'h0002);
      for (int k = 0; k < 3; k++) pop({8'h00, 8'h5a ^ k[7:0]}, 16'hffff);
      check("command", cfcp_far_i.cmd, `CFCP_CMD_WORD);
      end_load();
      check("clk_park", {o_config_clock_oe, o_config_clock}, 2'b10);
      check("user_oe", o_data_oe[1:0], 2'b10);
   endtask
   task automatic t_self_flash(input logic wm);
      int r;
      restart(`CFCP_SELF_FLASH, wm, 1'b0);
      i_scheme = `CFCP_HOST_SERIAL;
      tick(200);
      r = cfcp_far_i.rises;
      tick(100);
      check("frozen", cfcp_far_i.rises, r);
      check("clk_oe", o_config_clock_oe, 1'b1);
      for (int k = 0; k < 10; k++) pop({8'ha5 ^ k[7:0], 8'h5a ^ k[7:0]}, {{8{wm}}, 8'hff});
      end_load();
      i_user_clk_io_en = 1'b1;
      i_user_clk_oe = 1'b1;
      tick(3);
      check("clk_user", {o_config_clock_oe, o_config_clock}, 2'b11);
      check("uclk_in", o_user_clk_in, 1'b1);
      check("user_oe", o_data_oe, 16'h5a3c);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      error_cnt = 0;
      check_count = 0;
      cycles = 0;
      i_sys_rst = 1'b1;
      {i_start, i_load_done, i_flash_word_mode, i_cfg_ready, far_serial} = 5'h00;
      {i_user_clk_io_en, i_user_clk_oe} = 2'h0;
      i_user_clk_out = 1'b1;
      i_scheme = `CFCP_HOST_SERIAL;
      i_user_out = 16'h0ff0;
      i_user_oe = 16'h5a3c;
      tick(12);
      t_host_bytewide();
      t_host_serial();
      t_self_serial();
      t_self_flash(1'b0);
      t_self_flash(1'b1);
      summarize();
   end
endmodule
